//--- logic/rcf_apb_decode.sv
// APB address decode and access strobes for the reset cause block.
// Strobes span the whole access phase; the top picks the cycle that acts.
module rcf_apb_decode
    import rcf_pkg::*;
(
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    // Decoded strobes
    output logic             wr_status,
    output logic             wr_irq_en,
    output logic             wr_irq_clr,
    output logic             wr_ds_ctrl,
    output logic             rd_access,
    output logic             bad_addr
);

    logic access;
    logic hit;

    always_comb
    begin
        access     = psel && penable;
        hit        = (paddr == RCF_OFF_STATUS) || (paddr == RCF_OFF_IRQ_EN)
                     || (paddr == RCF_OFF_IRQ_CLR) || (paddr == RCF_OFF_DS_CTRL)
                     || (paddr == RCF_OFF_WDT_STAT);
        wr_status  = access && pwrite && (paddr == RCF_OFF_STATUS);
        wr_irq_en  = access && pwrite && (paddr == RCF_OFF_IRQ_EN);
        wr_irq_clr = access && pwrite && (paddr == RCF_OFF_IRQ_CLR);
        wr_ds_ctrl = access && pwrite && (paddr == RCF_OFF_DS_CTRL);
        rd_access  = access && !pwrite;
        bad_addr   = access && !hit;
    end

endmodule

//--- logic/rcf_event_mux.sv
// Maps hardware cause events onto status bit set and clear vectors.
// Assumes event inputs are one-cycle pulses synchronous to pclk.
module rcf_event_mux
    import rcf_pkg::*;
(
    // Cause events
    input  wire logic        trap_conflict,
    input  wire logic        illegal_instruction,
    input  wire logic        config_mismatch,
    input  wire logic        master_clear_pin,
    input  wire logic        reset_instruction,
    input  wire logic        watchdog_expired,
    input  wire logic        brownout,
    input  wire logic [1:0]  power_save_instruction,
    input  wire logic        deep_sleep_enable,
    // Result
    output logic      [15:0] hw_set,
    output logic      [15:0] hw_clr
);

    always_comb
    begin
        hw_set = 16'h0000;
        hw_clr = 16'h0000;
        hw_set[RCF_BIT_TRAP]    = trap_conflict;
        hw_set[RCF_BIT_ILLEGAL] = illegal_instruction;
        hw_set[RCF_BIT_CFGMIS]  = config_mismatch;
        hw_set[RCF_BIT_EXTRST]  = master_clear_pin;
        hw_set[RCF_BIT_SWRST]   = reset_instruction;
        hw_set[RCF_BIT_WATCHDOG_TIMEOUT_FLAG]    = watchdog_expired;
        hw_set[RCF_BIT_BOR]     = brownout;
        hw_set[RCF_BIT_SLEEP]   = power_save_instruction == RCF_PS_SLEEP;
        hw_set[RCF_BIT_IDLE]    = power_save_instruction == RCF_PS_IDLE;
        hw_set[RCF_BIT_DSLP]    = (power_save_instruction == RCF_PS_SLEEP)
                                  && deep_sleep_enable;
        // Any power-save instruction clears the time-out flag
        hw_clr[RCF_BIT_WATCHDOG_TIMEOUT_FLAG]    = power_save_instruction != RCF_PS_NONE;
    end

endmodule

//--- logic/rcf_pkg.sv
// Package for the reset cause flag register block.
// Assumes one clock domain (pclk) and an APB register interface.
package rcf_pkg;

    // Register byte offsets
    localparam logic [11:0] RCF_OFF_STATUS   = 12'h000;
    localparam logic [11:0] RCF_OFF_IRQ_EN   = 12'h004;
    localparam logic [11:0] RCF_OFF_IRQ_CLR  = 12'h008;
    localparam logic [11:0] RCF_OFF_DS_CTRL  = 12'h00C;
    localparam logic [11:0] RCF_OFF_WDT_STAT = 12'h010;

    // Field positions in reset_cause_status
    localparam int RCF_BIT_POR     = 0;
    localparam int RCF_BIT_BOR     = 1;
    localparam int RCF_BIT_IDLE    = 2;
    localparam int RCF_BIT_SLEEP   = 3;
    localparam int RCF_BIT_WATCHDOG_TIMEOUT_FLAG    = 4;
    localparam int RCF_BIT_SOFT_WATCHDOG_ENABLE  = 5;
    localparam int RCF_BIT_SWRST   = 6;
    localparam int RCF_BIT_EXTRST  = 7;
    localparam int RCF_BIT_CFGMIS  = 9;
    localparam int RCF_BIT_DSLP    = 10;
    localparam int RCF_BIT_ILLEGAL = 14;
    localparam int RCF_BIT_TRAP    = 15;
    // Deep sleep enable inside deep_sleep_control
    localparam int RCF_BIT_DEEP_SLEEP_ENABLE    = 15;

    localparam int RCF_REG_W = 16;

    // Implemented bits of reset_cause_status
    localparam logic [15:0] RCF_STATUS_MASK  = 16'hC6FF;
    // Flag bits only (enable bit excluded)
    localparam logic [15:0] RCF_FLAG_MASK    = 16'hC6DF;
    // Power-on value: power-on and brown-out flags set
    localparam logic [15:0] RCF_STATUS_RESET = 16'h0003;
    localparam logic [15:0] RCF_DSCTRL_MASK  = 16'h8000;

    // Power-save instruction kinds
    typedef enum logic [1:0]
    {
        RCF_PS_NONE,
        RCF_PS_IDLE,
        RCF_PS_SLEEP
    } rcf_ps_e;

endpackage

//--- logic/rcf_top.sv
// Reset cause flag register: sticky cause flags, watchdog enable, APB access.
// Assumes events are synchronous one-cycle pulses on pclk; power-on reset is presetn.
//
// Register access over APB and the address map were chosen for this implementation.

// Notes on behaviour
// - Bit 5 software enables or disables watchdog.
// - Unprogrammed fuse forces watchdog always on.
// - Time-out sets bit 4; power-save clears it.
// - Sleep instruction sets bit 3.
// - Idle instruction sets bit 2.
// - Brown-out or power-on sets bit 1.
// - Power-on sets bit 0.
// - Software sets or clears flags, never resets.
// - Trap sets bit 15, illegal op bit 14.
// - Mismatch bit 9, pin bit 7, instruction 6.
// - Sleep with deep-sleep enable sets bit 10.
module rcf_top
    import rcf_pkg::*;
(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Cause events
    input  wire logic        trap_conflict,
    input  wire logic        illegal_instruction,
    input  wire logic        config_mismatch,
    input  wire logic        master_clear_pin,
    input  wire logic        reset_instruction,
    input  wire logic        watchdog_expired,
    input  wire logic        brownout,
    input  wire logic [1:0]  power_save_instruction,
    // Configuration
    input  wire logic        watchdog_config_fuse,
    // Outputs
    output logic             watchdog_timer_enable,
    output logic             irq
);

    logic [15:0] reset_cause_status;
    logic [15:0] next_reset_cause_status;
    logic [15:0] irq_enable;
    logic [15:0] next_irq_enable;
    logic [15:0] irq_status;
    logic [15:0] next_irq_status;
    logic [15:0] deep_sleep_control;
    logic [15:0] next_deep_sleep_control;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        next_pready;
    logic        next_irq;
    logic        next_wdt_en;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic        wr_status;
    logic        wr_irq_en;
    logic        wr_irq_clr;
    logic        wr_ds_ctrl;
    logic        rd_access;
    logic        bad_addr;
    logic        deep_sleep_enable;

    assign deep_sleep_enable = deep_sleep_control[RCF_BIT_DEEP_SLEEP_ENABLE];

    rcf_event_mux rcf_event_mux_inst
    (
        .trap_conflict          (trap_conflict),
        .illegal_instruction    (illegal_instruction),
        .config_mismatch        (config_mismatch),
        .master_clear_pin       (master_clear_pin),
        .reset_instruction      (reset_instruction),
        .watchdog_expired       (watchdog_expired),
        .brownout               (brownout),
        .power_save_instruction (power_save_instruction),
        .deep_sleep_enable      (deep_sleep_enable),
        .hw_set                 (hw_set),
        .hw_clr                 (hw_clr)
    );

    rcf_apb_decode rcf_apb_decode_inst
    (
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .wr_status  (wr_status),
        .wr_irq_en  (wr_irq_en),
        .wr_irq_clr (wr_irq_clr),
        .wr_ds_ctrl (wr_ds_ctrl),
        .rd_access  (rd_access),
        .bad_addr   (bad_addr)
    );

    // Sticky flag update: clear first, then set, so a same-cycle set wins
    function automatic logic [15:0] sticky_update
    (
        input logic [15:0] current,
        input logic [15:0] set_bits,
        input logic [15:0] clr_bits
    );
        sticky_update = (current & ~clr_bits) | set_bits;
    endfunction

    // Status register next value
    always_comb
    begin
        next_reset_cause_status = reset_cause_status;
        // Writes land on the last access cycle only
        if (wr_status && pready)
        begin
            // Plain store only; nothing here feeds any reset path
            next_reset_cause_status = pwdata[15:0] & RCF_STATUS_MASK;
        end
        // Power-save clear of the time-out flag loses to a same-cycle set
        next_reset_cause_status = sticky_update(next_reset_cause_status,
                                                hw_set & RCF_FLAG_MASK,
                                                hw_clr);
    end

    // Watchdog enable follows the status value being stored
    always_comb
    begin
        next_wdt_en = watchdog_config_fuse
                      || next_reset_cause_status[RCF_BIT_SOFT_WATCHDOG_ENABLE];
    end

    // Status and watchdog enable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_cause_status    <= RCF_STATUS_RESET;
            watchdog_timer_enable <= 1'b0;
        end
        else
        begin
            reset_cause_status    <= next_reset_cause_status;
            watchdog_timer_enable <= next_wdt_en;
        end
    end

    // Interrupt status and enable next values
    always_comb
    begin
        next_irq_enable = irq_enable;
        if (wr_irq_en && pready)
        begin
            next_irq_enable = pwdata[15:0] & RCF_FLAG_MASK;
        end
        next_irq_status = irq_status;
        if (wr_irq_clr && pready)
        begin
            next_irq_status = sticky_update(irq_status, 16'h0000, pwdata[15:0]);
        end
        next_irq_status = sticky_update(next_irq_status, hw_set & RCF_FLAG_MASK,
                                        16'h0000);
        next_irq        = |(next_irq_status & next_irq_enable);
    end

    // Interrupt registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_enable <= 16'h0000;
            irq_status <= 16'h0000;
            irq        <= 1'b0;
        end
        else
        begin
            irq_enable <= next_irq_enable;
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

    // Deep sleep control next value
    always_comb
    begin
        next_deep_sleep_control = deep_sleep_control;
        if (wr_ds_ctrl && pready)
        begin
            next_deep_sleep_control = pwdata[15:0] & RCF_DSCTRL_MASK;
        end
    end

    // Deep sleep control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deep_sleep_control <= 16'h0000;
        end
        else
        begin
            deep_sleep_control <= next_deep_sleep_control;
        end
    end

    // Bus answer: one wait state, so data and error stand while pready is high
    always_comb
    begin
        next_pready  = psel && penable && !pready;
        next_pslverr = bad_addr && !pready;
        next_prdata  = 32'h0000_0000;
        if (rd_access && !pready)
        begin
            unique case (paddr)
                RCF_OFF_STATUS:   next_prdata = {16'h0000, reset_cause_status};
                RCF_OFF_IRQ_EN:   next_prdata = {16'h0000, irq_enable};
                RCF_OFF_IRQ_CLR:  next_prdata = {16'h0000, irq_status};
                RCF_OFF_DS_CTRL:  next_prdata = {16'h0000, deep_sleep_control};
                RCF_OFF_WDT_STAT: next_prdata = {31'h0000_0000, watchdog_timer_enable};
                default:          next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
            pready  <= next_pready;
        end
    end

endmodule

//--- sim/rcf_chk.sv
// Port-level assertions for rcf_top: cause flags on read, watchdog enable.
// Assumes binding to rcf_top; single pclk domain, presetn async low.
module rcf_chk
    import rcf_pkg::*;
(
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Events and watchdog
    input wire logic        trap_conflict,
    input wire logic        master_clear_pin,
    input wire logic        watchdog_expired,
    input wire logic        brownout,
    input wire logic [1:0]  power_save_instruction,
    input wire logic        watchdog_config_fuse,
    input wire logic        watchdog_timer_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rd_st;
    logic wr_st;
    // Completing edge of a status access; read data came from the cycle before
    assign rd_st = psel && penable && pready && !pwrite && paddr == RCF_OFF_STATUS;
    assign wr_st = psel && penable && pready && pwrite && paddr == RCF_OFF_STATUS;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_fuse_forces_on: assert property ($past(presetn) && $past(watchdog_config_fuse) |-> watchdog_timer_enable)
        else $error("fuse did not force watchdog on");
    a_soft_enable_write: assert property (wr_st |=> watchdog_timer_enable == ($past(pwdata[5]) | $past(watchdog_config_fuse)))
        else $error("watchdog enable does not follow write");
    a_trap_flag_read: assert property (rd_st
        && ($past(trap_conflict, 3) || $past(trap_conflict, 2)) |-> prdata[15])
        else $error("trap flag missing on read");
    a_pin_flag_read: assert property (rd_st
        && ($past(master_clear_pin, 3) || $past(master_clear_pin, 2)) |-> prdata[7])
        else $error("pin reset flag missing on read");
    a_timeout_flag_read: assert property (rd_st
        && ($past(watchdog_expired, 2)
        || ($past(watchdog_expired, 3) && $past(power_save_instruction, 2) == 2'h0))
        |-> prdata[4])
        else $error("time-out flag missing on read");
    a_brownout_flag_read: assert property (rd_st
        && ($past(brownout, 3) || $past(brownout, 2)) |-> prdata[1])
        else $error("brown-out flag missing on read");
    a_sleep_flag_read: assert property (rd_st
        && ($past(power_save_instruction, 3) == 2'h2 || $past(power_save_instruction, 2) == 2'h2)
        |-> prdata[3])
        else $error("sleep flag missing on read");
    a_idle_flag_read: assert property (rd_st
        && $past(power_save_instruction, 3) == 2'h1 && !$past(watchdog_expired, 3)
        && !$past(watchdog_expired, 2) |-> prdata[2] && !prdata[4])
        else $error("idle flag wrong on read");
endmodule
bind rcf_top rcf_chk rcf_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .trap_conflict, .master_clear_pin, .watchdog_expired, .brownout,
    .power_save_instruction, .watchdog_config_fuse, .watchdog_timer_enable);

//--- sim/reset_cause_flag_register_bench.sv
// Self-checking bench for rcf_top over APB with cause event pulses.
// Assumes rcf_pkg, rcf_top and rcf_chk compiled before it.
module reset_cause_flag_register_bench
    import rcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EV_POS [7] = '{15, 14, 9, 7, 6, 4, 1};
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        fuse    = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [6:0]  ev      = 7'h00;
    logic [1:0]  ps      = 2'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, wd_en, irq;
    logic [15:0] w;
    logic [6:0]  e;
    int          fails       = 0;
    int          checks_done = 0;
    always #5 pclk = ~pclk;
    rcf_top rcf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trap_conflict(ev[0]), .illegal_instruction(ev[1]),
        .config_mismatch(ev[2]), .master_clear_pin(ev[3]), .reset_instruction(ev[4]),
        .watchdog_expired(ev[5]), .brownout(ev[6]), .power_save_instruction(ps),
        .watchdog_config_fuse(fuse), .watchdog_timer_enable(wd_en), .irq);
    function automatic logic [15:0] ev_bits(logic [6:0] x);
        ev_bits = 16'h0000;
        for (int k = 0; k < 7; k++)
            if (x[k]) ev_bits[EV_POS[k]] = 1'b1;
    endfunction
    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; events ride on the access phase; data taken at the ready edge
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [6:0] x = 7'h00);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ev      <= x;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            finish_test();
        end
        else
        begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            ev      <= 7'h00;
            @(posedge pclk);
        end
    endtask
    task automatic pulse(logic [6:0] x, logic [1:0] p);
        ev <= x;
        ps <= p;
        @(posedge pclk);
        ev <= 7'h00;
        ps <= 2'h0;
    endtask
    task automatic rd_st(logic [15:0] exp);
        apb(1'b0, RCF_OFF_STATUS, 32'h0);
        check(rd, {16'h0000, exp});
    endtask
    task automatic irq_is(logic v);
        @(posedge pclk);
        check({31'h0, irq}, {31'h0, v});
    endtask
    initial
    begin
        void'($urandom(62));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_st(16'h0003);
        check({31'h0, wd_en}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, RCF_OFF_STATUS, 32'h0);
            pulse(7'h01 << i, 2'h0);
            rd_st(ev_bits(7'h01 << i));
        end
        $display("test events done");
        apb(1'b1, RCF_OFF_STATUS, 32'h0);
        pulse(7'h20, 2'h0);
        pulse(7'h00, 2'h1);
        rd_st(16'h0004);
        pulse(7'h20, 2'h0);
        pulse(7'h00, 2'h2);
        rd_st(16'h000C);
        apb(1'b1, RCF_OFF_DS_CTRL, 32'h8000);
        pulse(7'h00, 2'h2);
        rd_st(16'h040C);
        $display("test power save done");
        apb(1'b1, RCF_OFF_STATUS, 32'h0, 7'h01);
        rd_st(16'h8000);
        apb(1'b1, RCF_OFF_STATUS, 32'h20);
        check({31'h0, wd_en}, 32'h1);
        apb(1'b1, RCF_OFF_STATUS, 32'h0);
        check({31'h0, wd_en}, 32'h0);
        fuse <= 1'b1;
        repeat (2) @(posedge pclk);
        check({31'h0, wd_en}, 32'h1);
        fuse <= 1'b0;
        $display("test watchdog done");
        apb(1'b1, RCF_OFF_IRQ_CLR, 32'hFFFF);
        apb(1'b1, RCF_OFF_IRQ_EN, 32'h8000);
        pulse(7'h02, 2'h0);
        irq_is(1'b0);
        pulse(7'h01, 2'h0);
        irq_is(1'b1);
        apb(1'b1, RCF_OFF_IRQ_EN, 32'h0);
        irq_is(1'b0);
        apb(1'b1, RCF_OFF_IRQ_EN, 32'hFFFF);
        irq_is(1'b1);
        apb(1'b1, RCF_OFF_IRQ_CLR, 32'hFFFF);
        irq_is(1'b0);
        apb(1'b1, 12'h040, 32'hFFFF);
        check({31'h0, err}, 32'h1);
        rd_st(16'hC000);
        $display("test irq and refusal done");
        for (int i = 0; i < 40; i++)
        begin
            w = 16'($urandom());
            e = 7'($urandom());
            apb(1'b1, RCF_OFF_STATUS, {16'h0000, w}, e);
            rd_st((w & RCF_STATUS_MASK) | ev_bits(e));
        end
        $display("test random done");
        finish_test();
    end
endmodule
